// ===== logic/pasw_write_control.v
`timescale 1ns/10ps
`include "pasw_regs.vh"

// Functional notes
// - Both-pass update from bits 22:20; others ROP
// - Decode three-bit stencil operation codes
// - Increment clamps at all-ones of planes
// - Reference from data pins or constant source
// - Stencil test function from bits 18:16
// - Stencil control resets to 0x33300000
// - Stateless writes see stencil reset values
// - Select bits gate pass inputs into enable
// - Pass-input select resets to 0x00000100
// - Colour-depth bit 0 picks blend format
// - Colour-depth select resets to zero
// - Colour depth still applies to stateless writes
// - Stateless writes pass data, force pass out
// - Initial write loads word tags, clears rest
// - Normal write ORs byte enables into tags
// - Stateful writes gated by passes and compares
// - Plane enables mark data bits 31:24
// - Value mask selects compared stencil bits
// - Stencil-fail update from bits 30:28
// - Depth-fail update from bits 26:24

module pasw_write_control (
    input wire core_clk,
    input wire rst,
    input wire [2:0] aluOpcode,
    input wire [5:0] aluAddress,
    input wire [31:0] aluDataPins,
    input wire [3:0] aluByteEnables,
    input wire [7:0] constSourceHigh,
    input wire [31:0] oldData,
    input wire [31:0] ropData,
    input wire magPass,
    input wire matchPass,
    input wire [1:0] passIn,
    input wire [2:0] dirtyTagRdBlock,
    output reg bufWriteEn_q,
    output reg [5:0] bufAddr_q,
    output reg [31:0] bufWriteData_q,
    output reg [3:0] bufByteEn_q,
    output reg passOut_q,
    output reg ctrlReadValid_q,
    output reg [31:0] ctrlReadData_q,
    output reg [31:0] dirtyTagRdData_q,
    output wire colorDepth16
);

    // ****************************************
    // Helpers
    // ****************************************
    function [31:0] mergeField;
        input [31:0] oldV;
        input [31:0] newV;
        input [31:0] mask;
        begin
            mergeField = (oldV & ~mask) | (newV & mask);
        end
    endfunction

    // ****************************************
    // Control registers
    // ****************************************
    reg [31:0] stencilPlanes_q;
    reg [31:0] stencilControl_q;
    reg [31:0] passInSelect_q;
    reg [31:0] colorDepth_q;
    reg [31:0] dirtyTag_q [0:7];
    reg [31:0] readMux;

    wire isCtrlWrite = aluOpcode == `PASW_OP_WR_CTRL;
    wire isCtrlRead = aluOpcode == `PASW_OP_RD_CTRL;
    wire isStateless = (aluOpcode == `PASW_OP_SL_INIT) ||
        (aluOpcode == `PASW_OP_SL_NORMAL);
    wire isStateful = (aluOpcode == `PASW_OP_SF_INIT) ||
        (aluOpcode == `PASW_OP_SF_NORMAL);
    wire isInit = (aluOpcode == `PASW_OP_SL_INIT) ||
        (aluOpcode == `PASW_OP_SF_INIT);
    wire isDataWrite = isStateless || isStateful;

    always @* begin
        case (aluAddress)
            `PASW_ADDR_STPLANES: readMux = stencilPlanes_q;
            `PASW_ADDR_STCTRL: readMux = stencilControl_q;
            `PASW_ADDR_PINSEL: readMux = passInSelect_q;
            `PASW_ADDR_CDEPTH: readMux = colorDepth_q;
            default: readMux = 32'h00000000;
        endcase
    end

    // ****************************************
    // Effective stencil settings
    // ****************************************
    // Stateless writes never look at the programmed stencil state
    wire [31:0] effPlanes = isStateless ? `PASW_STPLANES_RESET : stencilPlanes_q;
    wire [31:0] effCtrl = isStateless ? `PASW_STCTRL_RESET : stencilControl_q;
    wire [7:0] planeEnable = effPlanes[`PASW_PLANE_EN_HI:`PASW_PLANE_EN_LO];
    wire [7:0] refVal = effCtrl[`PASW_REFSEL_BIT] ? constSourceHigh :
        aluDataPins[31:24];

    wire stencilPass;
    wire [7:0] newStencil;

    pasw_stencil_unit u_stencil (
        .planeEnable(planeEnable),
        .valueMask(effPlanes[`PASW_VMASK_HI:`PASW_VMASK_LO]),
        .testFunc(effCtrl[`PASW_FUNC_HI:`PASW_FUNC_LO]),
        .opFail(effCtrl[`PASW_OPFAIL_HI:`PASW_OPFAIL_LO]),
        .opDepthFail(effCtrl[`PASW_OPDFAIL_HI:`PASW_OPDFAIL_LO]),
        .opBothPass(effCtrl[`PASW_OPBOTH_HI:`PASW_OPBOTH_LO]),
        .refVal(refVal),
        .oldVal(oldData[31:24]),
        .ropVal(ropData[31:24]),
        .magPass(magPass),
        .stencilPass(stencilPass),
        .newStencil(newStencil)
    );

    // ****************************************
    // Write enable
    // ****************************************
    // A disabled pass input reads as one
    wire passIn1Eff = passInSelect_q[`PASW_PIN1_EN_BIT] ? passIn[1] : 1'b1;
    wire passIn0Eff = passInSelect_q[`PASW_PIN0_EN_BIT] ? passIn[0] : 1'b1;
    wire gatedPass = passIn1Eff & passIn0Eff;
    wire anyPlane = |planeEnable;
    wire bothPass = stencilPass & magPass;

    // With stencil planes on, a failed test still writes its stencil update,
    // so only the match compare and the pass inputs may hold the word back
    wire statefulPassOut = matchPass & (magPass | anyPlane);
    wire writeAllowed = isStateless |
        (isStateful & gatedPass & statefulPassOut);

    // Colour bits follow the ROP only when every test passed
    wire [23:0] lowBits = bothPass ? ropData[23:0] : oldData[23:0];
    wire [31:0] statefulData = {newStencil, lowBits};
    wire [31:0] writeData = isStateless ? aluDataPins : statefulData;

    // Blend format is exported to the ROP/blend path in every mode
    assign colorDepth16 = colorDepth_q[`PASW_CDEPTH_BIT];

    // ****************************************
    // Register file
    // ****************************************
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stencilPlanes_q <= `PASW_STPLANES_RESET;
            stencilControl_q <= `PASW_STCTRL_RESET;
            passInSelect_q <= `PASW_PINSEL_RESET;
            colorDepth_q <= `PASW_CDEPTH_RESET;
        end else if (isCtrlWrite) begin
            case (aluAddress)
                `PASW_ADDR_STPLANES: begin
                    stencilPlanes_q <= mergeField(stencilPlanes_q, aluDataPins,
                        `PASW_STPLANES_MASK);
                end
                `PASW_ADDR_STCTRL: begin
                    stencilControl_q <= mergeField(stencilControl_q, aluDataPins,
                        `PASW_STCTRL_MASK);
                end
                `PASW_ADDR_PINSEL: begin
                    passInSelect_q <= mergeField(passInSelect_q, aluDataPins,
                        `PASW_PINSEL_MASK);
                end
                `PASW_ADDR_CDEPTH: begin
                    colorDepth_q <= mergeField(colorDepth_q, aluDataPins,
                        `PASW_CDEPTH_MASK);
                end
                default: begin
                    stencilPlanes_q <= stencilPlanes_q;
                end
            endcase
        end
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrlReadValid_q <= 1'b0;
            ctrlReadData_q <= 32'h00000000;
        end else begin
            ctrlReadValid_q <= isCtrlRead;
            if (isCtrlRead) begin
                ctrlReadData_q <= readMux;
            end
        end
    end

    // ****************************************
    // Buffer write port
    // ****************************************
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bufWriteEn_q <= 1'b0;
            bufAddr_q <= 6'h00;
            bufWriteData_q <= 32'h00000000;
            bufByteEn_q <= 4'h0;
            passOut_q <= 1'b1;
        end else begin
            bufWriteEn_q <= isDataWrite & writeAllowed;
            if (isDataWrite) begin
                bufAddr_q <= aluAddress;
                bufWriteData_q <= writeData;
                bufByteEn_q <= aluByteEnables;
                passOut_q <= isStateless | statefulPassOut;
            end
        end
    end

    // ****************************************
    // Dirty tags
    // ****************************************
    // Address bits 5:3 pick the block, 2:0 the word within it
    integer blk;
    integer wrd;
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (blk = 0; blk < 8; blk = blk + 1) begin
                dirtyTag_q[blk] <= 32'h00000000;
            end
            dirtyTagRdData_q <= 32'h00000000;
        end else begin
            dirtyTagRdData_q <= dirtyTag_q[dirtyTagRdBlock];
            if (isDataWrite && writeAllowed) begin
                for (wrd = 0; wrd < 8; wrd = wrd + 1) begin
                    if (wrd == aluAddress[2:0]) begin
                        if (isInit) begin
                            dirtyTag_q[aluAddress[5:3]][wrd*4 +: 4] <=
                                aluByteEnables;
                        end else begin
                            dirtyTag_q[aluAddress[5:3]][wrd*4 +: 4] <=
                                dirtyTag_q[aluAddress[5:3]][wrd*4 +: 4] |
                                aluByteEnables;
                        end
                    end else if (isInit) begin
                        dirtyTag_q[aluAddress[5:3]][wrd*4 +: 4] <= 4'h0;
                    end
                end
            end
        end
    end

endmodule // pasw_write_control

// ===== logic/pasw_regs.vh
`ifndef PASW_REGS_VH
`define PASW_REGS_VH

// ****************************************
// ALU opcodes
// ****************************************
`define PASW_OP_SL_INIT 3'h0
`define PASW_OP_SL_NORMAL 3'h1
`define PASW_OP_SF_INIT 3'h2
`define PASW_OP_SF_NORMAL 3'h3
`define PASW_OP_NOP 3'h4
`define PASW_OP_RD_CTRL 3'h6
`define PASW_OP_WR_CTRL 3'h7

// ****************************************
// Control register addresses
// ****************************************
`define PASW_ADDR_STPLANES 6'h1a
`define PASW_ADDR_STCTRL 6'h1b
`define PASW_ADDR_PINSEL 6'h1c
`define PASW_ADDR_CDEPTH 6'h1d

// ****************************************
// Reset values and writable bits
// ****************************************
`define PASW_STPLANES_RESET 32'h00ff0000
`define PASW_STCTRL_RESET 32'h33300000
`define PASW_PINSEL_RESET 32'h00000100
`define PASW_CDEPTH_RESET 32'h00000000
`define PASW_STPLANES_MASK 32'hffff0000
`define PASW_STCTRL_MASK 32'h777f0000
`define PASW_PINSEL_MASK 32'h00000101
`define PASW_CDEPTH_MASK 32'h00000001

// ****************************************
// Field positions
// ****************************************
`define PASW_PLANE_EN_HI 31
`define PASW_PLANE_EN_LO 24
`define PASW_VMASK_HI 23
`define PASW_VMASK_LO 16
`define PASW_OPFAIL_HI 30
`define PASW_OPFAIL_LO 28
`define PASW_OPDFAIL_HI 26
`define PASW_OPDFAIL_LO 24
`define PASW_OPBOTH_HI 22
`define PASW_OPBOTH_LO 20
`define PASW_REFSEL_BIT 19
`define PASW_FUNC_HI 18
`define PASW_FUNC_LO 16
`define PASW_PIN1_EN_BIT 0
`define PASW_PIN0_EN_BIT 8
`define PASW_CDEPTH_BIT 0

// ****************************************
// Stencil operations and test functions
// ****************************************
`define PASW_SOP_ZERO 3'h0
`define PASW_SOP_KEEP 3'h1
`define PASW_SOP_INVERT 3'h2
`define PASW_SOP_REPLACE 3'h3
`define PASW_SOP_INCR_A 3'h4
`define PASW_SOP_INCR_B 3'h6
`define PASW_FN_ALWAYS 3'h0
`define PASW_FN_GREATER 3'h1
`define PASW_FN_EQUAL 3'h2
`define PASW_FN_GEQUAL 3'h3
`define PASW_FN_NEVER 3'h4
`define PASW_FN_LEQUAL 3'h5
`define PASW_FN_NOTEQUAL 3'h6

`endif

// ===== logic/pasw_stencil_unit.v
`timescale 1ns/10ps
`include "pasw_regs.vh"

module pasw_stencil_unit (
    input wire [7:0] planeEnable,
    input wire [7:0] valueMask,
    input wire [2:0] testFunc,
    input wire [2:0] opFail,
    input wire [2:0] opDepthFail,
    input wire [2:0] opBothPass,
    input wire [7:0] refVal,
    input wire [7:0] oldVal,
    input wire [7:0] ropVal,
    input wire magPass,
    output reg stencilPass,
    output reg [7:0] newStencil
);

    // ****************************************
    // Helpers
    // ****************************************
    function [2:0] lowBit;
        input [7:0] en;
        integer i;
        begin
            lowBit = 3'h0;
            for (i = 7; i >= 0; i = i - 1) begin
                if (en[i]) begin
                    lowBit = i[2:0];
                end
            end
        end
    endfunction

    // Counting works on the plane group moved down to bit 0, so it
    // only behaves when the enabled planes are one contiguous run
    function [7:0] applyOp;
        input [2:0] op;
        input [7:0] oldV;
        input [7:0] refV;
        input [7:0] en;
        reg [2:0] sh;
        reg [7:0] cur;
        reg [7:0] top;
        reg [7:0] res;
        begin
            sh = lowBit(en);
            cur = (oldV & en) >> sh;
            top = en >> sh;
            case (op)
                `PASW_SOP_ZERO: res = 8'h00;
                `PASW_SOP_KEEP: res = cur;
                `PASW_SOP_INVERT: res = (~oldV & en) >> sh;
                `PASW_SOP_REPLACE: res = (refV & en) >> sh;
                `PASW_SOP_INCR_A, `PASW_SOP_INCR_B: res = (cur == top) ? cur : cur + 8'h01;
                default: res = (cur == 8'h00) ? cur : cur - 8'h01;
            endcase
            applyOp = (res << sh) & en;
        end
    endfunction

    // ****************************************
    // Test and update
    // ****************************************
    wire [7:0] refMasked = refVal & valueMask;
    wire [7:0] oldMasked = oldVal & valueMask;

    always @* begin
        case (testFunc)
            `PASW_FN_ALWAYS: stencilPass = 1'b1;
            `PASW_FN_GREATER: stencilPass = refMasked > oldMasked;
            `PASW_FN_EQUAL: stencilPass = refMasked == oldMasked;
            `PASW_FN_GEQUAL: stencilPass = refMasked >= oldMasked;
            `PASW_FN_NEVER: stencilPass = 1'b0;
            `PASW_FN_LEQUAL: stencilPass = refMasked <= oldMasked;
            `PASW_FN_NOTEQUAL: stencilPass = refMasked != oldMasked;
            default: stencilPass = refMasked < oldMasked;
        endcase
    end

    always @* begin
        if (!stencilPass) begin
            newStencil = applyOp(opFail, oldVal, refVal, planeEnable) |
                (oldVal & ~planeEnable);
        end else if (!magPass) begin
            newStencil = applyOp(opDepthFail, oldVal, refVal, planeEnable) |
                (oldVal & ~planeEnable);
        end else begin
            newStencil = applyOp(opBothPass, oldVal, refVal, planeEnable) |
                (ropVal & ~planeEnable);
        end
    end

endmodule // pasw_stencil_unit

// ===== verif/pasw_props_properties.sv
`timescale 1ns/10ps
module pasw_props (
    input wire core_clk,
    input wire rst,
    input wire [2:0] aluOpcode,
    input wire [5:0] aluAddress,
    input wire [31:0] aluDataPins,
    input wire [3:0] aluByteEnables,
    input wire matchPass,
    input wire [2:0] dirtyTagRdBlock,
    input wire bufWriteEn_q,
    input wire [31:0] bufWriteData_q,
    input wire passOut_q,
    input wire ctrlReadValid_q,
    input wire [31:0] ctrlReadData_q,
    input wire [31:0] dirtyTagRdData_q,
    input wire colorDepth16
);
    // ****************************************
    // Port properties
    // ****************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_wrDepth;
        aluOpcode == 3'h7 && aluAddress == 6'h1d ##2 aluOpcode == 3'h6 && aluAddress == 6'h1d;
    endsequence
    sequence s_initBlk;
        aluOpcode == 3'h0 && dirtyTagRdBlock == aluAddress[5:3] ##1 $stable(dirtyTagRdBlock);
    endsequence
    property p_slWrite;
        aluOpcode <= 3'h1 |=> bufWriteEn_q && passOut_q && bufWriteData_q == $past(aluDataPins);
    endproperty
    a_slWrite: assert property (p_slWrite) else $error("stateless write altered");
    property p_mismatch;
        (aluOpcode == 3'h2 || aluOpcode == 3'h3) && !matchPass |=> !bufWriteEn_q && !passOut_q;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("failed compare wrote");
    property p_wrNeedsPass;
        bufWriteEn_q |-> passOut_q;
    endproperty
    a_wrNeedsPass: assert property (p_wrNeedsPass) else $error("write with pass low");
    property p_noWrite;
        aluOpcode[2] |=> !bufWriteEn_q;
    endproperty
    a_noWrite: assert property (p_noWrite) else $error("write without data op");
    property p_depthRead;
        s_wrDepth |=> ctrlReadValid_q && ctrlReadData_q == {31'h0, $past(aluDataPins[0], 3)};
    endproperty
    a_depthRead: assert property (p_depthRead) else $error("depth readback wrong");
    property p_depthLevel;
        aluOpcode == 3'h7 && aluAddress == 6'h1d |=> colorDepth16 == $past(aluDataPins[0]);
    endproperty
    a_depthLevel: assert property (p_depthLevel) else $error("depth level wrong");
    property p_tagInit;
        s_initBlk |=> dirtyTagRdData_q ==
            ({28'h0, $past(aluByteEnables, 2)} << {$past(aluAddress[2:0], 2), 2'b00});
    endproperty
    a_tagInit: assert property (p_tagInit) else $error("initial tags wrong");
    property p_rstVals;
        disable iff (1'b0) rst |-> passOut_q && !bufWriteEn_q && !colorDepth16 && !ctrlReadValid_q;
    endproperty
    a_rstVals: assert property (p_rstVals) else $error("reset outputs wrong");
endmodule // pasw_props

bind pasw_write_control pasw_props u_props (
    .core_clk(core_clk), .rst(rst), .aluOpcode(aluOpcode), .aluAddress(aluAddress),
    .aluDataPins(aluDataPins), .aluByteEnables(aluByteEnables), .matchPass(matchPass),
    .dirtyTagRdBlock(dirtyTagRdBlock), .bufWriteEn_q(bufWriteEn_q),
    .bufWriteData_q(bufWriteData_q), .passOut_q(passOut_q), .ctrlReadValid_q(ctrlReadValid_q),
    .ctrlReadData_q(ctrlReadData_q), .dirtyTagRdData_q(dirtyTagRdData_q),
    .colorDepth16(colorDepth16)
);

// ===== verif/pasw_ctrl_model.sv
`timescale 1ns/10ps
module pasw_ctrl_model (
    input wire core_clk,
    input wire bufWriteEn_q,
    input wire [5:0] bufAddr_q,
    input wire [31:0] bufWriteData_q,
    output reg [2:0] aluOpcode,
    output reg [5:0] aluAddress,
    output reg [31:0] aluDataPins,
    output reg [3:0] aluByteEnables,
    output wire [31:0] oldData
);
    // ****************************************
    // Controller and pixel buffer model
    // ****************************************
    reg [31:0] mem [0:63];
    integer n;
    initial begin
        aluOpcode = 3'h4;
        aluAddress = 6'h00;
        aluDataPins = 32'h0;
        aluByteEnables = 4'h0;
        for (n = 0; n < 64; n = n + 1) mem[n] = 32'h25c3a55a ^ n;
    end
    assign oldData = mem[aluAddress];
    always @(posedge core_clk) begin
        if (bufWriteEn_q) begin
            mem[bufAddr_q] <= bufWriteData_q;
        end
    end
    // A NOP follows every op: gives the gap after a depth write and breaks test-mode runs
    task op(input [2:0] o, input [5:0] a, input [31:0] d, input [3:0] b);
        @(posedge core_clk);
        aluOpcode <= o;
        aluAddress <= a;
        aluDataPins <= d;
        aluByteEnables <= b;
        @(posedge core_clk);
        aluOpcode <= 3'h4;
        aluAddress <= ~a;
        aluDataPins <= ~d;
    endtask
endmodule // pasw_ctrl_model

// ===== verif/tb.sv
`timescale 1ns/10ps
module tb;
    reg core_clk;
    reg rst;
    reg [7:0] constSourceHigh;
    reg [31:0] ropData;
    reg magPass;
    reg matchPass;
    reg [1:0] passIn;
    reg [2:0] dirtyTagRdBlock;
    wire [2:0] aluOpcode;
    wire [5:0] aluAddress;
    wire [31:0] aluDataPins;
    wire [3:0] aluByteEnables;
    wire [31:0] oldData;
    wire bufWriteEn_q;
    wire [5:0] bufAddr_q;
    wire [3:0] bufByteEn_q;
    wire [31:0] bufWriteData_q;
    wire passOut_q;
    wire ctrlReadValid_q;
    wire [31:0] ctrlReadData_q;
    wire [31:0] dirtyTagRdData_q;
    wire colorDepth16;
    integer failures, compares, cycles, i, j, k;
    reg [7:0] pl, vm;
    reg [2:0] fn, opF, opZ, opP;
    reg rs;
    reg [31:0] tg;
    localparam [95:0] MSK = {32'h1, 32'h101, 32'h777f0000};
    localparam [23:0] OLDV = {8'hff, 8'h00, 8'h97};
    localparam [23:0] REFS = {8'h14, 8'h35, 8'h26};
    // ****************************************
    // Harness
    // ****************************************
    pasw_write_control uut (
        .core_clk(core_clk), .rst(rst), .aluOpcode(aluOpcode), .aluAddress(aluAddress),
        .aluDataPins(aluDataPins), .aluByteEnables(aluByteEnables),
        .constSourceHigh(constSourceHigh), .oldData(oldData), .ropData(ropData),
        .magPass(magPass), .matchPass(matchPass), .passIn(passIn),
        .dirtyTagRdBlock(dirtyTagRdBlock), .bufWriteEn_q(bufWriteEn_q), .bufAddr_q(bufAddr_q),
        .bufWriteData_q(bufWriteData_q), .bufByteEn_q(bufByteEn_q), .passOut_q(passOut_q),
        .ctrlReadValid_q(ctrlReadValid_q), .ctrlReadData_q(ctrlReadData_q),
        .dirtyTagRdData_q(dirtyTagRdData_q), .colorDepth16(colorDepth16)
    );
    pasw_ctrl_model drv (
        .core_clk(core_clk), .bufWriteEn_q(bufWriteEn_q), .bufAddr_q(bufAddr_q),
        .bufWriteData_q(bufWriteData_q), .aluOpcode(aluOpcode), .aluAddress(aluAddress),
        .aluDataPins(aluDataPins), .aluByteEnables(aluByteEnables), .oldData(oldData)
    );
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Tests need about 750 cycles; the ceiling leaves wide margin
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 8000) begin
            failures = failures + 1;
            results;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task results;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task wr(input [5:0] a, input [31:0] d);
        drv.op(3'h7, a, d, 4'h0);
    endtask
    task rd(input [5:0] a, input [31:0] e);
        drv.op(3'h6, a, 32'h0, 4'h0);
        #1;
        chk({31'h0, ctrlReadValid_q}, 32'h1);
        chk(ctrlReadData_q, e);
    endtask
    task setc(input m, input t, input [1:0] p, input [2:0] b);
        @(posedge core_clk);
        magPass <= m;
        matchPass <= t;
        passIn <= p;
        dirtyTagRdBlock <= b;
    endtask
    // Assumes contiguous planes, as increment and decrement need
    function [7:0] sopf(input [2:0] op, input [7:0] en, input [7:0] o, input [7:0] r);
        integer lo;
        reg [7:0] f;
        reg [7:0] v;
        lo = 0;
        while (lo < 7 && !en[lo]) lo = lo + 1;
        f = (o & en) >> lo;
        case (op)
            3'h0: v = 8'h00;
            3'h1: v = f;
            3'h2: v = ~f;
            3'h3: v = r >> lo;
            3'h4, 3'h6: v = (f == (en >> lo)) ? f : f + 8'h01;
            default: v = (f == 8'h00) ? f : f - 8'h01;
        endcase
        sopf = (v << lo) & en;
    endfunction
    function tst(input [7:0] r, input [7:0] o);
        case (fn)
            3'h0: tst = 1'b1;
            3'h1: tst = (r & vm) > (o & vm);
            3'h2: tst = (r & vm) == (o & vm);
            3'h3: tst = (r & vm) >= (o & vm);
            3'h4: tst = 1'b0;
            3'h5: tst = (r & vm) <= (o & vm);
            3'h6: tst = (r & vm) != (o & vm);
            default: tst = (r & vm) < (o & vm);
        endcase
    endfunction
    task cfg(input [7:0] p, m, input [2:0] f, a, b, c, input r);
        pl = p;
        vm = m;
        fn = f;
        opF = a;
        opZ = b;
        opP = c;
        rs = r;
        wr(6'h1a, {p, m, 16'h0});
        wr(6'h1b, {1'b0, a, 1'b0, b, 1'b0, c, r, f, 16'h0});
    endtask
    task sf(input [5:0] a, input [31:0] d);
        reg [31:0] o;
        reg [7:0] r;
        reg [7:0] s;
        reg p;
        @(posedge core_clk);
        #1;
        o = drv.mem[a];
        r = rs ? constSourceHigh : d[31:24];
        p = tst(r, o[31:24]);
        if (!p) s = sopf(opF, pl, o[31:24], r) | (o[31:24] & ~pl);
        else if (!magPass) s = sopf(opZ, pl, o[31:24], r) | (o[31:24] & ~pl);
        else s = sopf(opP, pl, o[31:24], r) | (ropData[31:24] & ~pl);
        drv.op(3'h3, a, d, 4'hf);
        #1;
        chk({31'h0, bufWriteEn_q}, 32'h1);
        chk(bufWriteData_q, (p && magPass) ? {s, ropData[23:0]} : {s, o[23:0]});
    endtask
    task sl(input [2:0] op, input [5:0] a, input [3:0] be, input [31:0] et);
        drv.op(op, a, {a, 26'h2d1e0f}, be);
        #1;
        chk({31'h0, passOut_q & bufWriteEn_q}, 32'h1);
        chk(bufWriteData_q, {a, 26'h2d1e0f});
        chk({28'h0, bufByteEn_q}, {28'h0, be});
        @(posedge core_clk);
        #1;
        chk(dirtyTagRdData_q, et);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task t_regs;
        rd(6'h1b, 32'h33300000);
        rd(6'h1c, 32'h00000100);
        rd(6'h1d, 32'h00000000);
        for (i = 0; i < 3; i = i + 1) begin
            wr(6'h1b + i[5:0], 32'hffffffff);
            rd(6'h1b + i[5:0], MSK[i*32 +: 32]);
        end
        chk({31'h0, colorDepth16}, 32'h1);
        rd(6'h10, 32'h0);
        $display("register test done");
    endtask
    task t_sl;
        wr(6'h1a, 32'hffff0000);
        setc(1'b0, 1'b0, 2'b00, 3'h1);
        sl(3'h0, 6'o12, 4'h5, 32'h00000500);
        sl(3'h1, 6'o13, 4'h2, 32'h00002500);
        sl(3'h0, 6'o10, 4'hf, 32'h0000000f);
        chk({31'h0, colorDepth16}, 32'h1);
        wr(6'h1d, 32'h0);
        $display("stateless test done");
    endtask
    task t_func;
        setc(1'b1, 1'b1, 2'b11, 3'h1);
        for (i = 0; i < 8; i = i + 1) begin
            cfg(8'hff, 8'h0f, i[2:0], 3'h0, 3'h1, 3'h3, 1'b0);
            for (j = 0; j < 3; j = j + 1) begin
                sf(6'h10 + i[5:0] * 6'h3 + j[5:0], {REFS[j*8 +: 8], 24'h3c4b5a});
            end
        end
        $display("compare test done");
    endtask
    task t_ops;
        for (i = 0; i < 8; i = i + 1) begin
            for (j = 0; j < 3; j = j + 1) begin
                setc(j == 2, 1'b1, 2'b11, 3'h1);
                cfg(8'h3c, 8'hff, (j == 0) ? 3'h4 : 3'h0, i[2:0], i[2:0], i[2:0], 1'b1);
                for (k = 0; k < 3; k = k + 1) begin
                    drv.op(3'h1, 6'h30 + k[5:0], {OLDV[k*8 +: 8], 24'h0}, 4'hf);
                    sf(6'h30 + k[5:0], 32'h0);
                end
            end
        end
        $display("operation test done");
    endtask
    task t_gate;
        cfg(8'h00, 8'hff, 3'h0, 3'h1, 3'h1, 3'h1, 1'b0);
        setc(1'b1, 1'b1, 2'b11, 3'h7);
        drv.op(3'h0, 6'o77, 32'h0, 4'h0);
        tg = 32'h0;
        for (i = 0; i < 16; i = i + 1) begin
            wr(6'h1c, {23'h0, i[3], 7'h0, i[2]});
            setc(1'b1, 1'b1, i[1:0], 3'h7);
            drv.op(3'h2, {3'h7, i[2:0]}, 32'h0, ~i[3:0]);
            #1;
            k = (!i[2] || i[1]) && (!i[3] || i[0]);
            chk({31'h0, bufWriteEn_q}, k);
            chk({31'h0, passOut_q}, 32'h1);
            if (k) tg = {28'h0, ~i[3:0]} << (i[2:0] * 4);
            @(posedge core_clk);
            #1;
            chk(dirtyTagRdData_q, tg);
        end
        setc(1'b1, 1'b0, 2'b11, 3'h7);
        drv.op(3'h3, 6'o70, 32'h0, 4'hf);
        #1;
        chk({30'h0, bufWriteEn_q, passOut_q}, 32'h0);
        $display("gating test done");
    endtask
    initial begin
        rst = 1'b1;
        constSourceHigh = 8'hb7;
        ropData = 32'h5a5a5a5a;
        magPass = 1'b0;
        matchPass = 1'b0;
        passIn = 2'b00;
        dirtyTagRdBlock = 3'h0;
        failures = 0;
        compares = 0;
        cycles = 0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        t_regs;
        t_sl;
        t_func;
        t_ops;
        t_gate;
        results;
    end
endmodule // tb
